// >>> logic/srmcu_defs.vh
// constants for the soft reset / machine check exception unit
`ifndef SRMCU_DEFS_VH
`define SRMCU_DEFS_VH
// apb byte offsets
`define SRMCU_OFF_HWCFG      12'h000
`define SRMCU_OFF_SRADDR     12'h004
`define SRMCU_OFF_SRCAUSE    12'h008
`define SRMCU_OFF_MSTATE     12'h00C
`define SRMCU_OFF_STATUS     12'h010
`define SRMCU_OFF_PC         12'h014
// configuration bits (bit 0 is the msb in the documented numbering)
`define SRMCU_CFG_MCPEN      31
`define SRMCU_CFG_PGDIS      30
`define SRMCU_CFG_APCHK      29
`define SRMCU_CFG_DPCHK      28
`define SRMCU_CFG_NHR        16
// machine state bits, msb-0 numbering mapped to lsb-0 positions
`define SRMCU_MS_POW         18
`define SRMCU_MS_ILE         16
`define SRMCU_MS_EE          15
`define SRMCU_MS_PR          14
`define SRMCU_MS_FP          13
`define SRMCU_MS_ME          12
`define SRMCU_MS_FE0         11
`define SRMCU_MS_SE          10
`define SRMCU_MS_BE          9
`define SRMCU_MS_FE1         8
`define SRMCU_MS_IP          6
`define SRMCU_MS_IR          5
`define SRMCU_MS_DR          4
`define SRMCU_MS_PM          2
`define SRMCU_MS_RI          1
`define SRMCU_MS_LE          0
// cause bits in save/restore cause register
`define SRMCU_CS_DMA         21
`define SRMCU_CS_L2DB        20
`define SRMCU_CS_MCP         19
`define SRMCU_CS_TEA         18
`define SRMCU_CS_DPAR        17
`define SRMCU_CS_APAR        16
// reset values
`define SRMCU_RST_HWCFG      32'h0000_0000
`define SRMCU_RST_MSTATE     32'h0000_0040
`define SRMCU_RST_SRCAUSE    32'h0000_0040
`define SRMCU_RST_ZERO       32'h0000_0000
// bits kept on exception entry: interrupt prefix and exception little endian
`define SRMCU_MS_KEEP        32'h0001_0040
// vectors
`define SRMCU_VEC_RESET      32'h0000_0100
`define SRMCU_VEC_MCHK       32'h0000_0200
`define SRMCU_BASE_HIGH      32'hFFF0_0000
// checkstop freeze delay in cycles
`define SRMCU_FREEZE_CYC     2'h2
// states
`define SRMCU_ST_RUN         3'h0
`define SRMCU_ST_DRAIN       3'h1
`define SRMCU_ST_TAKE        3'h2
`define SRMCU_ST_CKWAIT      3'h3
`define SRMCU_ST_CKSTOP      3'h4
`endif

// >>> logic/srmcu_unit.v
// soft reset and machine check exception unit with apb registers
`include "srmcu_defs.vh"
module srmcu_unit (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clk_en,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        hard_reset_in,
  input  wire        soft_reset_in,
  input  wire        machine_check_pin,
  input  wire        transfer_error_ack,
  input  wire        checkstop_input,
  input  wire        bus_addr_parity_err,
  input  wire        bus_data_parity_err,
  input  wire        l1_parity_err,
  input  wire        l2_double_bit_err,
  input  wire        dma_locked_miss,
  input  wire        dcbz_locked_hit,
  input  wire        completion_empty,
  input  wire [31:0] current_ea,
  output wire        block_completion,
  output wire        discard_stores,
  output wire        parity_gen_disable,
  output reg         vector_valid,
  output reg  [31:0] vector_addr,
  output wire        checkstop,
  output wire        core_freeze
);
  reg [31:0] hw_config_machine_check_enables;
  reg [31:0] save_restore_address;
  reg [31:0] save_restore_cause_state;
  reg [31:0] machine_state;
  reg [2:0]  state;
  reg [2:0]  next_state;
  reg        soft_reset_in_d;
  reg        soft_reset_in_pend;
  reg [5:0]  pend_cause;
  reg [1:0]  freeze_cnt;
  reg        last_was_mchk;
  reg        unrecoverable;
  wire       acc;
  wire       wr;
  wire       rd_ok;
  wire       me;
  wire       soft_reset_in_edge;
  wire       pin_mc;
  wire [5:0] new_cause;
  wire       mc_any;
  wire [31:0] base;
  wire       frozen;

  assign frozen = (state == `SRMCU_ST_CKSTOP);
  assign acc = psel & penable;
  assign pready = 1'b1;
  assign rd_ok = (paddr == `SRMCU_OFF_HWCFG) | (paddr == `SRMCU_OFF_SRADDR) |
                 (paddr == `SRMCU_OFF_SRCAUSE) | (paddr == `SRMCU_OFF_MSTATE) |
                 (paddr == `SRMCU_OFF_STATUS) | (paddr == `SRMCU_OFF_PC);
  assign pslverr = acc & ~rd_ok;
  // registers are frozen in checkstop, writes then ignored
  assign wr = acc & pwrite & rd_ok & ~frozen;
  assign me = machine_state[`SRMCU_MS_ME];
  assign parity_gen_disable = hw_config_machine_check_enables[`SRMCU_CFG_PGDIS];
  assign soft_reset_in_edge = soft_reset_in & ~soft_reset_in_d & ~hard_reset_in;
  assign pin_mc = machine_check_pin & hw_config_machine_check_enables[`SRMCU_CFG_MCPEN];
  // cause gathering; writeback error arrives as tea
  assign new_cause = {
    dma_locked_miss | dcbz_locked_hit,
    l2_double_bit_err | l1_parity_err,
    pin_mc,
    transfer_error_ack,
    bus_data_parity_err & hw_config_machine_check_enables[`SRMCU_CFG_DPCHK],
    bus_addr_parity_err & hw_config_machine_check_enables[`SRMCU_CFG_APCHK]};
  assign mc_any = |new_cause | (|pend_cause);
  assign base = machine_state[`SRMCU_MS_IP] ? `SRMCU_BASE_HIGH : `SRMCU_RST_ZERO;
  assign block_completion = (state == `SRMCU_ST_DRAIN) | (state == `SRMCU_ST_TAKE);
  // stores dropped when machine check taken
  assign discard_stores = (state == `SRMCU_ST_TAKE) & last_was_mchk;
  assign checkstop = (state == `SRMCU_ST_CKWAIT) | frozen;
  assign core_freeze = frozen;

  always @* begin
    next_state = state;
    case (state)
      `SRMCU_ST_RUN: begin
        if (checkstop_input | (mc_any & ~me))
          next_state = `SRMCU_ST_CKWAIT;
        else if (mc_any)
          next_state = `SRMCU_ST_TAKE;
        else if (soft_reset_in_pend)
          next_state = `SRMCU_ST_DRAIN;
      end
      `SRMCU_ST_DRAIN: begin
        if (checkstop_input | (mc_any & ~me))
          next_state = `SRMCU_ST_CKWAIT;
        else if (mc_any | completion_empty)
          next_state = `SRMCU_ST_TAKE;
      end
      `SRMCU_ST_TAKE: next_state = `SRMCU_ST_RUN;
      `SRMCU_ST_CKWAIT: begin
        if (freeze_cnt == `SRMCU_FREEZE_CYC - 2'h1)
          next_state = `SRMCU_ST_CKSTOP;
      end
      `SRMCU_ST_CKSTOP: next_state = `SRMCU_ST_CKSTOP;
      default: next_state = `SRMCU_ST_RUN;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state                           <= `SRMCU_ST_RUN;
      soft_reset_in_d                        <= 1'b0;
      soft_reset_in_pend                     <= 1'b0;
      pend_cause                      <= 6'h00;
      freeze_cnt                      <= 2'h0;
      last_was_mchk                   <= 1'b0;
      unrecoverable                   <= 1'b0;
      vector_valid                    <= 1'b0;
      vector_addr                     <= `SRMCU_RST_ZERO;
      hw_config_machine_check_enables <= `SRMCU_RST_HWCFG;
      save_restore_address            <= `SRMCU_RST_ZERO;
      save_restore_cause_state        <= `SRMCU_RST_SRCAUSE;
      machine_state                   <= `SRMCU_RST_MSTATE;
    end else if (hard_reset_in) begin
      // hard reset clears config, flag included
      state                           <= `SRMCU_ST_RUN;
      soft_reset_in_d                        <= 1'b0;
      soft_reset_in_pend                     <= 1'b0;
      pend_cause                      <= 6'h00;
      freeze_cnt                      <= 2'h0;
      last_was_mchk                   <= 1'b0;
      unrecoverable                   <= 1'b0;
      vector_valid                    <= 1'b1;
      vector_addr                     <= `SRMCU_BASE_HIGH | `SRMCU_VEC_RESET;
      hw_config_machine_check_enables <= `SRMCU_RST_HWCFG;
      save_restore_address            <= `SRMCU_RST_ZERO;
      save_restore_cause_state        <= `SRMCU_RST_SRCAUSE;
      machine_state                   <= `SRMCU_RST_MSTATE;
    end else if (clk_en & ~frozen) begin
      state        <= next_state;
      soft_reset_in_d     <= soft_reset_in;
      vector_valid <= 1'b0;
      if (state == `SRMCU_ST_CKWAIT)
        freeze_cnt <= freeze_cnt + 2'h1;
      if (soft_reset_in_edge)
        soft_reset_in_pend <= 1'b1;
      if (state != `SRMCU_ST_TAKE)
        pend_cause <= pend_cause | new_cause;
      if (state == `SRMCU_ST_DRAIN && mc_any)
        unrecoverable <= 1'b1;
      if (wr && paddr == `SRMCU_OFF_HWCFG)
        hw_config_machine_check_enables <= pwdata;
      if (wr && paddr == `SRMCU_OFF_SRADDR)
        save_restore_address <= pwdata;
      if (wr && paddr == `SRMCU_OFF_SRCAUSE)
        save_restore_cause_state <= pwdata;
      // software may set the enable again here
      if (wr && paddr == `SRMCU_OFF_MSTATE)
        machine_state <= pwdata;
      if (state == `SRMCU_ST_RUN || state == `SRMCU_ST_DRAIN) begin
        last_was_mchk <= mc_any;
      end
      if (state == `SRMCU_ST_TAKE) begin
        save_restore_address <= current_ea;
        // ile and ip stay as they were, le takes the exception endianness
        machine_state <= (machine_state & `SRMCU_MS_KEEP) |
                         {31'h0000_0000, machine_state[`SRMCU_MS_ILE]};
        vector_valid <= 1'b1;
        if (last_was_mchk) begin
          save_restore_cause_state <= {10'h000, pend_cause, machine_state[15:0]};
          vector_addr <= base | `SRMCU_VEC_MCHK;
          pend_cause  <= new_cause;
        end else begin
          // recoverable bit kept from state unless drain hit a check
          save_restore_cause_state <= {16'h0000, machine_state[15:2],
                                       machine_state[`SRMCU_MS_RI] & ~unrecoverable,
                                       machine_state[0]};
          vector_addr   <= base | `SRMCU_VEC_RESET;
          soft_reset_in_pend   <= soft_reset_in_edge;
          unrecoverable <= 1'b0;
        end
      end
    end
  end

  always @* begin
    case (paddr)
      `SRMCU_OFF_HWCFG:   prdata = hw_config_machine_check_enables;
      `SRMCU_OFF_SRADDR:  prdata = save_restore_address;
      `SRMCU_OFF_SRCAUSE: prdata = save_restore_cause_state;
      `SRMCU_OFF_MSTATE:  prdata = machine_state;
      `SRMCU_OFF_STATUS:  prdata = {26'h000_0000, checkstop, soft_reset_in_pend, 1'b0, state};
      `SRMCU_OFF_PC:      prdata = {26'h000_0000, pend_cause};
      default:            prdata = `SRMCU_RST_ZERO;
    endcase
  end
endmodule

// >>> sim/srmcu_far_end.sv
// external reset logic and completion queue stand-in
module srmcu_far_end (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       srst_req,
  input  wire [3:0] depth,
  input  wire       block_completion,
  output wire       soft_reset_in,
  output wire       completion_empty
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] queue_left;
  logic [1:0] pulse_left;
  assign completion_empty = (queue_left == 4'h0);
  assign soft_reset_in = (pulse_left != 2'h0);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      queue_left <= 4'h0;
      pulse_left <= 2'h0;
    end else if (srst_req) begin
      // three-cycle pulse, no scan activity exists here
      pulse_left <= 2'h3;
      queue_left <= depth;
    end else begin
      if (pulse_left != 2'h0) pulse_left <= pulse_left - 2'h1;
      // queue only empties while completion is blocked
      if (block_completion && queue_left != 4'h0) queue_left <= queue_left - 4'h1;
    end
  end
endmodule

// >>> sim/srmcu_unit_chk.sv
// port-level assertions for the exception unit
module srmcu_unit_chk (
  input wire        pclk,
  input wire        presetn,
  input wire        hard_reset_in,
  input wire        soft_reset_in,
  input wire        checkstop_input,
  input wire        completion_empty,
  input wire        block_completion,
  input wire        discard_stores,
  input wire        vector_valid,
  input wire [31:0] vector_addr,
  input wire        checkstop,
  input wire        core_freeze
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  vec_pulse_a:
    assert property (vector_valid && !hard_reset_in |=> !vector_valid) else $error("long vector");
  vec_base_a:
    assert property (vector_valid |-> vector_addr[19:0] inside {20'h0_0100, 20'h0_0200}
      && vector_addr[31:20] inside {12'h000, 12'hfff}) else $error("bad vector address");
  hrst_first_a:
    assert property (hard_reset_in |=> vector_valid && vector_addr == 32'hfff0_0100
      && !checkstop) else $error("hard reset vector wrong");
  ckin_stop_a:
    assert property (checkstop_input && !hard_reset_in |-> ##[1:3] checkstop)
      else $error("checkstop input ignored");
  freeze_two_a:
    assert property ($rose(checkstop) |-> ##[1:2] core_freeze) else $error("late freeze");
  stop_hold_a:
    assert property (checkstop && !hard_reset_in |=> checkstop) else $error("checkstop left");
  frozen_quiet_a:
    assert property (core_freeze && !hard_reset_in |=> !vector_valid && !discard_stores)
      else $error("activity while frozen");
  drain_block_a:
    assert property (block_completion && !completion_empty && !discard_stores && !hard_reset_in
      |=> block_completion) else $error("drain released early");
  mc_take_a:
    assert property (discard_stores && !hard_reset_in |-> block_completion
      ##1 (vector_valid && vector_addr[11:0] == 12'h200)) else $error("machine check entry");
  srst_vec_a:
    assert property ($rose(soft_reset_in) && !hard_reset_in |-> ##[2:40]
      (vector_valid && vector_addr[11:0] == 12'h100)) else $error("soft reset not taken");
  cover property (discard_stores);
  cover property ($rose(core_freeze));
  cover property (block_completion && !completion_empty);
endmodule
bind srmcu_unit srmcu_unit_chk chk (.*);

// >>> sim/test_soft_reset_machine_check_unit.sv
// self-checking bench for the soft reset / machine check unit
module test_soft_reset_machine_check_unit;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 0, presetn = 0, clk_en = 1, bus_addr_parity_err = 0, hard_reset_in = 0;
  logic        psel = 0, penable = 0, pwrite = 0, srst_req = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, current_ea = 0, rd, ms, cfg;
  logic [7:0]  src = 0, s;
  logic [3:0]  depth = 0;
  wire  [31:0] prdata, vector_addr;
  wire         pready, pslverr, block_completion, discard_stores, parity_gen_disable;
  wire         vector_valid, checkstop, core_freeze, soft_reset_in, completion_empty;
  wire         machine_check_pin, transfer_error_ack, checkstop_input, bus_data_parity_err;
  wire         l1_parity_err, l2_double_bit_err, dma_locked_miss, dcbz_locked_hit;
  integer      n_errors = 0, total_checks = 0;
  logic [31:0] rst_val [4] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0040, 32'h0000_0040};
  assign {checkstop_input, dcbz_locked_hit, dma_locked_miss, l2_double_bit_err, l1_parity_err,
    bus_data_parity_err, transfer_error_ack, machine_check_pin} = src;
  srmcu_unit dut (.*);
  srmcu_far_end far (.*);
  always #25 pclk = ~pclk;
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task pulse(input logic [7:0] v);
    @(posedge pclk);
    src <= v;
    @(posedge pclk);
    src <= 8'h00;
  endtask
  task wait_vec(input logic [31:0] exp);
    int i;
    i = 0;
    do begin @(posedge pclk); #1; i++; end while (vector_valid !== 1'b1 && i < 60);
    chk(vector_addr, exp);
  endtask
  function automatic logic [31:0] cause_of(input logic [7:0] v, input logic [31:0] m);
    return {10'h000, v[6] | v[5], v[4] | v[3], v[0], v[1], v[2], 1'b0, m[15:0]};
  endfunction
  function automatic logic [31:0] base(input logic [31:0] m);
    return m[6] ? 32'hfff0_0000 : 32'h0000_0000;
  endfunction
  task report_and_stop;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    rd = $urandom(29);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(0, 12'(i * 4), 0);
      chk(rd, rst_val[i]);
    end
    apb(1, 12'h018, 32'hffff_ffff);
    chk(err, 1);
    $display("register reset test done");
    // address parity check stays disabled, software keeps that bit clear
    for (int k = 0; k < 8; k++) begin
      s = (k == 7) ? 8'h03 : 8'(1 << k);
      ms = ($urandom & 32'h0005_ff77) | 32'h0000_1000;
      cfg = 32'h9000_0000 | ($urandom & 32'h4000_0000);
      current_ea <= $urandom & 32'hffff_fffc;
      apb(1, 12'h000, cfg);
      #1 chk(parity_gen_disable, cfg[30]);
      apb(1, 12'h00c, ms);
      pulse(s);
      wait_vec(base(ms) | 32'h0000_0200);
      apb(0, 12'h008, 0);
      chk(rd, cause_of(s, ms));
      apb(0, 12'h00c, 0);
      chk(rd, (ms & 32'h0001_0040) | {31'h0, ms[16]});
      apb(0, 12'h004, 0);
      chk(rd, current_ea);
    end
    $display("machine check test done");
    apb(1, 12'h000, 0);
    apb(1, 12'h00c, 0);
    pulse(8'h01);
    repeat (6) @(posedge pclk);
    chk(checkstop, 0);
    apb(0, 12'h00c, 0);
    chk(rd, 0);
    for (int k = 0; k < 3; k++) begin
      ms = ($urandom & 32'h0005_ff77) | 32'h0000_1000;
      apb(1, 12'h00c, ms);
      @(posedge pclk);
      srst_req <= 1'b1;
      depth <= 4'($urandom_range(15, 1));
      @(posedge pclk);
      srst_req <= 1'b0;
      wait_vec(base(ms) | 32'h0000_0100);
      chk(checkstop, 0);
      apb(0, 12'h008, 0);
      chk(rd, {16'h0000, ms[15:0]});
      apb(0, 12'h00c, 0);
      chk(rd & 32'h0000_0041, (ms & 32'h0000_0040) | {31'h0, ms[16]});
    end
    // simultaneous soft reset and bus error: the check goes first
    apb(1, 12'h00c, 32'h0000_1040);
    @(posedge pclk);
    srst_req <= 1'b1;
    depth <= 4'h3;
    @(posedge pclk);
    srst_req <= 1'b0;
    src <= 8'h02;
    @(posedge pclk);
    src <= 8'h00;
    wait_vec(32'hfff0_0200);
    wait_vec(32'hfff0_0100);
    $display("soft reset test done");
    for (int k = 0; k < 2; k++) begin
      ms = k ? 32'h0000_1000 : 32'h0000_0000;
      apb(1, 12'h000, 32'h8001_0000);
      apb(1, 12'h00c, ms);
      pulse(k ? 8'h80 : 8'h02);
      repeat (4) @(posedge pclk);
      chk(checkstop, 1);
      chk(core_freeze, 1);
      apb(1, 12'h00c, 32'h0000_1041);
      apb(0, 12'h00c, 0);
      chk(rd, ms);
      @(posedge pclk);
      hard_reset_in <= 1'b1;
      @(posedge pclk);
      hard_reset_in <= 1'b0;
      #1;
      chk(vector_valid, 1);
      chk(checkstop, 0);
      apb(0, 12'h000, 0);
      chk(rd, 0);
    end
    $display("checkstop test done");
    report_and_stop;
  end
  // generous bound, the full sequence needs well under a thousand cycles
  initial begin
    #200000;
    n_errors++;
    report_and_stop;
  end
endmodule
